// ==== core/ocr_regs.sv ====
`include "ocr_cfg.svh"
module ocr_regs #(
  parameter logic [7:0] PRODUCT_CODE = 8'hA5, // arbitrary value
  parameter logic [7:0] SILICON_REV = 8'h5A, // arbitrary value
  parameter int CAL_CYCLES = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hardResetPinB,
  input wire ocr_pkg::ocr_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic [7:0] nvmTargetAddr,
  input wire logic [7:0] nvmImageRev,
  input wire logic nvmCommitDone,
  input wire logic strapLow,
  input wire logic strapHigh,
  output logic pllEnable,
  output logic calBusy,
  output logic outputEnable,
  output logic deviceReset
);
  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  logic pinS1_q, pinS2_q, softRst_q, devRst_q;
  logic s1Lo_q, s2Lo_q, s1Hi_q, s2Hi_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinS1_q <= 1'b0;
      pinS2_q <= 1'b0;
      s1Lo_q <= 1'b0;
      s2Lo_q <= 1'b0;
      s1Hi_q <= 1'b0;
      s2Hi_q <= 1'b0;
    end else begin
      pinS1_q <= hardResetPinB;
      pinS2_q <= pinS1_q;
      s1Lo_q <= strapLow;
      s2Lo_q <= s1Lo_q;
      s1Hi_q <= strapHigh;
      s2Hi_q <= s1Hi_q;
    end
  end
  // one-shot: the soft reset write pulse gives a single reset cycle
  logic softWr;
  assign softWr = req.wr && req.addr == `OCR_ADDR_SOFTRST &&
                  req.wdata[`OCR_BIT_SOFTRST];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      softRst_q <= 1'b0;
    end else begin
      softRst_q <= softWr;
    end
  end
  // device reset: power-on, pin low, soft bit; held one cycle at least
  logic devRstNow;
  assign devRstNow = !pinS2_q || softRst_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      devRst_q <= 1'b1;
    end else begin
      devRst_q <= devRstNow;
    end
  end
  // ----------------------------------------------------------------
  // nvm-loaded values
  // ----------------------------------------------------------------
  logic [7:0] target_q, imgRev_q;
  logic [1:0] strapCode;
  always_comb begin
    if (s2Hi_q) begin
      strapCode = `OCR_STRAP_HIGH;
    end else if (s2Lo_q) begin
      strapCode = `OCR_STRAP_LOW;
    end else begin
      strapCode = `OCR_STRAP_FLOAT;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      target_q <= 8'h00;
    end else if (devRst_q) begin
      // reserved bit 0 forced low
      target_q <= {nvmTargetAddr[7:3], strapCode, 1'b0};
    end else begin
      target_q <= {target_q[7:3], strapCode, 1'b0};
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      imgRev_q <= 8'h00;
    end else if (devRst_q || nvmCommitDone) begin
      imgRev_q <= nvmImageRev;
    end
  end
  // ----------------------------------------------------------------
  // device control
  // ----------------------------------------------------------------
  logic [7:0] devCtl_q;
  logic ctlWr, calDone, calStart, pdnFall;
  ocr_pkg::ocr_state_t state_q;
  logic [7:0] calCnt_q;
  // only device_control and the soft reset byte decode writes; writes to
  // the read-only places fall through and leave them untouched
  assign ctlWr = req.wr && req.addr == `OCR_ADDR_DEVCTL;
  assign calDone = state_q == ocr_pkg::ST_CAL && calCnt_q == 8'h00;
  assign calStart = ctlWr && req.wdata[`OCR_BIT_CAL] &&
                    !devCtl_q[`OCR_BIT_CAL];
  assign pdnFall = ctlWr && !req.wdata[`OCR_BIT_PDN] &&
                   devCtl_q[`OCR_BIT_PDN];
  // power-down request decode, shared by the halt, calibrate and run states
  function automatic logic pdnSetWr(input ocr_pkg::ocr_req_t r);
    return r.wr && r.addr == `OCR_ADDR_DEVCTL && r.wdata[`OCR_BIT_PDN];
  endfunction
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      devCtl_q <= `OCR_DEVCTL_RST;
    end else begin
      if (ctlWr) begin
        devCtl_q <= req.wdata & `OCR_DEVCTL_WMASK;
      end
      // a new start in the finishing cycle keeps the bit set
      if (calDone && !calStart) begin
        devCtl_q[`OCR_BIT_CAL] <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // startup / calibration sequencer
  // ----------------------------------------------------------------
  logic autoWr;
  assign autoWr = ctlWr && req.wdata[`OCR_BIT_AUTO];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ocr_pkg::ST_CONFIG;
      calCnt_q <= 8'h00;
    end else if (devRst_q) begin
      state_q <= ocr_pkg::ST_CONFIG;
    end else begin
      unique case (state_q)
        ocr_pkg::ST_CONFIG: begin
          calCnt_q <= 8'(CAL_CYCLES - 1);
          if (devCtl_q[`OCR_BIT_PDN]) begin
            state_q <= ocr_pkg::ST_PDN;
          end else if (devCtl_q[`OCR_BIT_AUTO]) begin
            state_q <= ocr_pkg::ST_CAL;
          end else begin
            state_q <= ocr_pkg::ST_HALT;
          end
        end
        ocr_pkg::ST_HALT: begin
          calCnt_q <= 8'(CAL_CYCLES - 1);
          // parked until software asks for lock or power-down
          if (pdnSetWr(req)) begin
            state_q <= ocr_pkg::ST_PDN;
          end else if (autoWr || calStart) begin
            state_q <= ocr_pkg::ST_CAL;
          end
        end
        ocr_pkg::ST_CAL, ocr_pkg::ST_RUN: begin
          if (pdnSetWr(req)) begin
            state_q <= ocr_pkg::ST_PDN;
          end else if (calStart) begin
            state_q <= ocr_pkg::ST_CAL;
            calCnt_q <= 8'(CAL_CYCLES - 1);
          end else if (state_q == ocr_pkg::ST_CAL) begin
            if (calDone) begin
              state_q <= ocr_pkg::ST_RUN;
            end else begin
              calCnt_q <= calCnt_q - 8'h01;
            end
          end
        end
        ocr_pkg::ST_PDN: begin
          calCnt_q <= 8'(CAL_CYCLES - 1);
          if (pdnFall) begin
            state_q <= ocr_pkg::ST_CAL;
          end
        end
        default: begin
          state_q <= ocr_pkg::ST_CONFIG;
        end
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pllEnable <= 1'b0;
      calBusy <= 1'b0;
      outputEnable <= 1'b0;
      deviceReset <= 1'b1;
    end else begin
      pllEnable <= state_q == ocr_pkg::ST_CAL ||
                   state_q == ocr_pkg::ST_RUN;
      calBusy <= state_q == ocr_pkg::ST_CAL;
      outputEnable <= state_q == ocr_pkg::ST_RUN;
      deviceReset <= devRst_q;
    end
  end
  // ----------------------------------------------------------------
  // read port; writes elsewhere are silently dropped
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        unique case (req.addr)
          `OCR_ADDR_PRODUCT: rdata <= PRODUCT_CODE;
          `OCR_ADDR_SIREV: rdata <= SILICON_REV;
          `OCR_ADDR_TARGET: rdata <= target_q;
          `OCR_ADDR_IMGREV: rdata <= imgRev_q;
          `OCR_ADDR_DEVCTL: rdata <= devCtl_q;
          default: rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ==== core/ocr_cfg.svh ====
// Operation
// - product code is fixed read-only byte
// - silicon revision is fixed read-only byte
// - target address bits 7..3 from nvm
// - strap pin sets address bits 2..1
// - image revision reloads after reset, commit
// - power-down clear at reset with auto-start set starts calibration
// - power-down disables pll; clearing recalibrates
// - rising write of trigger starts calibration
// - trigger self-clears when calibration completes
// - auto-start locks pll, enables outputs
// - reset from power-on, pin, soft bit
// - auto-start clear at reset halts until auto-start or trigger is written one
`ifndef OCR_CFG_SVH
`define OCR_CFG_SVH
`define OCR_ADDR_PRODUCT 8'h02
`define OCR_ADDR_SIREV 8'h03
`define OCR_ADDR_TARGET 8'h08
`define OCR_ADDR_IMGREV 8'h09
`define OCR_ADDR_DEVCTL 8'h0A
`define OCR_ADDR_SOFTRST 8'h48
`define OCR_BIT_PDN 6
`define OCR_BIT_CAL 1
`define OCR_BIT_AUTO 0
`define OCR_BIT_SOFTRST 1
`define OCR_DEVCTL_WMASK 8'h7F
`define OCR_DEVCTL_RST 8'h01
`define OCR_STRAP_LOW 2'h0
`define OCR_STRAP_FLOAT 2'h1
`define OCR_STRAP_HIGH 2'h3
`endif

// ==== core/ocr_pkg.sv ====
package ocr_pkg;
  typedef enum logic [4:0] {
    ST_CONFIG = 5'h01,
    ST_HALT = 5'h02,
    ST_CAL = 5'h04,
    ST_RUN = 5'h08,
    ST_PDN = 5'h10
  } ocr_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ocr_req_t;
endpackage

// ==== dv/ocr_regs_sva.sv ====
module ocr_regs_sva #(
  parameter logic [7:0] PRODUCT_CODE = 8'hA5,
  parameter logic [7:0] SILICON_REV = 8'h5A,
  parameter int CAL_CYCLES = 16
) (
  input logic clk,
  input logic rst_b,
  input logic hardResetPinB,
  input ocr_pkg::ocr_req_t req,
  input logic [7:0] rdata,
  input logic [7:0] nvmTargetAddr,
  input logic strapHigh,
  input logic pllEnable,
  input logic calBusy,
  input logic outputEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_prod_read: assert property (
    req.rd && req.addr == 8'h02 |=> rdata == PRODUCT_CODE) else $error("prod");
  a_rev_read: assert property (
    req.rd && req.addr == 8'h03 |=> rdata == SILICON_REV) else $error("rev");
  a_addr_high: assert property (
    req.rd && req.addr == 8'h08 |=> (rdata >> 3) == ($past(nvmTargetAddr) >> 3))
    else $error("target address");
  a_strap_high: assert property (
    req.rd && req.addr == 8'h08 && strapHigh && $past(strapHigh, 3)
    |=> rdata[2:1] == 2'h3) else $error("strap");
  a_pdn_stops: assert property (
    req.wr && req.addr == 8'h0A && req.wdata[6] |-> ##[1:3] !pllEnable)
    else $error("pll still on");
  a_cal_self_clear: assert property (
    $rose(calBusy) |-> ##[1:40] !calBusy) else $error("cal stuck");
  a_out_after_lock: assert property (
    $rose(outputEnable) |-> pllEnable && !calBusy) else $error("early out");
  a_pin_reset: assert property (
    $fell(hardResetPinB) |-> ##5 !outputEnable) else $error("pin reset");
endmodule

// ==== dv/ocr_host_model.sv ====
module ocr_host_model (
  input logic clk,
  output ocr_pkg::ocr_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= {w, !w, a, d};
    @(posedge clk);
    // idle lines show the inverse so stale values are never trusted
    req <= {2'b00, ~a, ~d};
  endtask
endmodule

// ==== dv/tb_top.sv ====
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
  $display("Error at %0t: got %h want %h", $time, a, e); end end
`define WT(c) begin k = 0; while (!(c) && k < 300) begin \
  @(posedge clk); k++; end `CHK(c, 1'b1) end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, pinB = 1, commit = 0, sLow = 0, sHigh = 0;
  logic [7:0] tAddr = 8'hC8, iRev = 8'h3C, old, rdata;
  logic rvalid, pllEn, calBusy, outEn, devRst;
  logic [15:0] q[$];
  logic [15:0] e;
  ocr_pkg::ocr_req_t req;
  int failures = 0, n_tests = 0, k, cyc = 0;
  integer seed = 32'h10bd;
  ocr_regs #(.PRODUCT_CODE(8'h6E), .SILICON_REV(8'h91), .CAL_CYCLES(4))
  ocr_regs_inst (.clk(clk), .rst_b(rst_b), .hardResetPinB(pinB), .req(req),
    .rdata(rdata), .rvalid(rvalid), .nvmTargetAddr(tAddr), .nvmImageRev(iRev),
    .nvmCommitDone(commit), .strapLow(sLow), .strapHigh(sHigh),
    .pllEnable(pllEn), .calBusy(calBusy), .outputEnable(outEn),
    .deviceReset(devRst));
  ocr_host_model ocr_host_model_inst (.clk(clk), .req(req));
  initial forever #5 clk = ~clk;
  task conclude;
    if (q.size() != 0) failures++;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] ex, input logic [7:0] m);
    q.push_back({ex & m, m});
    ocr_host_model_inst.xfer(1'b0, a, 8'h00);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rvalid === 1'b1) begin
      e = q.pop_front();
      `CHK(rdata & e[7:0], e[15:8])
    end
    if (cyc == 20000) begin
      failures++;
      conclude;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1;
    `WT(devRst === 1'b0)
    `WT(outEn === 1'b1)
    rd(8'h0A, 8'h01, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      // read-only places take random writes and must not change
      ocr_host_model_inst.xfer(1'b1, 8'h02 + 8'(i), 8'($random(seed)));
      ocr_host_model_inst.xfer(1'b1, 8'h08, 8'($random(seed)));
      sLow <= (i == 0);
      sHigh <= (i == 2);
      repeat (4) @(posedge clk);
      rd(8'h08, {tAddr[7:3], 2'(i | (i >> 1)), 1'b0}, 8'hFE);
    end
    rd(8'h02, 8'h6E, 8'hFF);
    rd(8'h03, 8'h91, 8'hFF);
    old = iRev;
    iRev <= old ^ (8'($random(seed)) | 8'h01);
    rd(8'h09, old, 8'hFF);
    commit <= 1;
    @(posedge clk);
    commit <= 0;
    rd(8'h09, iRev, 8'hFF);
    rd(8'h55, 8'h00, 8'hFF);
    ocr_host_model_inst.xfer(1'b1, 8'h0A, 8'h41);
    `WT(pllEn === 1'b0)
    ocr_host_model_inst.xfer(1'b1, 8'h0A, 8'h01);
    `WT(calBusy === 1'b1)
    `WT(outEn === 1'b1)
    ocr_host_model_inst.xfer(1'b1, 8'h0A, 8'h03);
    `WT(calBusy === 1'b1)
    `WT(calBusy === 1'b0)
    rd(8'h0A, 8'h01, 8'hFF);
    iRev <= ~iRev;
    ocr_host_model_inst.xfer(1'b1, 8'h48, 8'h02);
    `WT(devRst === 1'b1)
    `WT(outEn === 1'b0)
    `WT(outEn === 1'b1)
    rd(8'h09, iRev, 8'hFF);
    pinB <= 0;
    `WT(devRst === 1'b1)
    pinB <= 1;
    `WT(outEn === 1'b0)
    `WT(outEn === 1'b1)
    // auto-start off: the next reset must stop short of lock
    ocr_host_model_inst.xfer(1'b1, 8'h0A, 8'h00);
    ocr_host_model_inst.xfer(1'b1, 8'h48, 8'h02);
    `WT(outEn === 1'b0)
    repeat (20) @(posedge clk);
    `CHK(pllEn, 1'b0)
    `CHK(outEn, 1'b0)
    ocr_host_model_inst.xfer(1'b1, 8'h0A, 8'h01);
    `WT(outEn === 1'b1)
    repeat (5) @(posedge clk);
    conclude;
  end
endmodule
bind ocr_regs ocr_regs_sva #(.PRODUCT_CODE(PRODUCT_CODE),
  .SILICON_REV(SILICON_REV), .CAL_CYCLES(CAL_CYCLES)) ocr_regs_sva_inst (
  .clk(clk), .rst_b(rst_b), .hardResetPinB(hardResetPinB), .req(req),
  .rdata(rdata), .nvmTargetAddr(nvmTargetAddr), .strapHigh(strapHigh),
  .pllEnable(pllEnable), .calBusy(calBusy), .outputEnable(outputEnable));
